/* File: rtl/fifo_sizing_defs.svh */
// Offsets, field positions, reset values and timing counts of the
// frame FIFO sizing, flow control and latency tolerance registers.
// Assumes a 40 MHz core clock and byte addresses on the register port.
`ifndef FIFO_SIZING_DEFS_SVH
`define FIFO_SIZING_DEFS_SVH

`define RX_FIFO_END_SEL_OFF 8'h00c8
`define TX_FIFO_END_SEL_OFF 8'h00cc
`define PAUSE_WATERMARKS_OFF 8'h00d0
`define RX_PATH_OCC_OFF 8'h00d4
`define TX_PATH_OCC_OFF 8'h00d8
`define LAT_IDLE_FAST_OFF 8'h00e0
`define LAT_IDLE_SLOW_OFF 8'h00e4
`define LAT_ACT_FAST_OFF 8'h00e8
`define LAT_ACT_SLOW_OFF 8'h00ec
`define FLOW_STATUS_OFF 8'h00f8
`define LTM_CTRL_OFF 8'h00fc

`define FIFO_END_RST 7'h17
`define FIFO_END_MUL 128
`define FIFO_END_ADD 127
`define FIFO_MAX_BYTES 16'h3000
`define WATERMARK_UNIT_SHIFT 9
`define WM_ON_LSB 0
`define WM_OFF_LSB 8
`define LAT_GIG_LSB 16
`define LAT_LOW_LSB 0
`define LAT_RST 12'h000

`define CLK_FREQ_HZ 40000000
`define LTM_STEP_US 100
`define LTM_STEP_CYCLES ((`CLK_FREQ_HZ / 1000000) * `LTM_STEP_US)

`endif

/* File: rtl/fifo_sizing_pkg.sv */
// Types shared by the FIFO sizing and latency tolerance register bank.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package fifo_sizing_pkg;
  typedef enum logic [1:0] {
    SPEED_10,
    SPEED_100,
    SPEED_1000,
    SPEED_NONE
  } link_speed_type;

  typedef enum logic {
    LTM_ACTIVE,
    LTM_IDLE
  } ltm_state_type;
endpackage : fifo_sizing_pkg
`default_nettype wire

/* File: rtl/fifo_sizing_flow_ltm_regs.sv */
// Register bank: FIFO end addresses, pause watermarks with hysteresis,
// data path occupancy, per-speed latency tolerance and the LTM state.
// Assumes occupancy counts come from the FIFOs on the same clock and
// that the latency image has been loaded before USB or lite resets.
//
// Design decision made here: the plain strobed port.
`include "fifo_sizing_defs.svh"
`default_nettype none

// Behaviour
// - Rx FIFO last address is end_sel*128+127 dwords, reset 17h.
// - Tx FIFO last address is 6-bit end_sel*128+127 dwords, reset 17h.
// - Each FIFO is at most 12 KB, which is also the reset size; larger end selects are not refused.
// - Watermark thresholds count receive occupancy in 512-byte units.
// - Flow control turns on when occupancy/512 >= on-threshold.
// - Flow control turns off when occupancy/512 <= off-threshold.
// - Rx path word: bits 31:16 total, 15:0 usb-out FIFO bytes.
// - Tx path word: bits 31:16 total, 15:0 usb-in FIFO bytes.
// - Idle latency chosen by speed: gig, fast eth, slow eth fields.
// - Active latency chosen by speed: gig, fast eth, slow eth fields.
// - Latency defaults from EEPROM, else OTP, else zero.
// - USB or lite reset restores latency fields to the loaded image.
// - Rx FIFO occupancy grows by dword-rounded length plus extras.
// - Idle entered when inactivity countdown in 100 us steps hits zero.
module fifo_sizing_flow_ltm_regs #(
  parameter int STEP_CYCLES = `LTM_STEP_CYCLES  // Cycles per 100 us step
) (
  input wire logic clk_in,  // Core clock, 40 MHz
  input wire logic rst_n_in,  // Asynchronous reset, active low
  input wire logic [7:0] addr_in,  // Register byte address
  input wire logic [31:0] wdata_in,  // Write data
  input wire logic wr_in,  // Write strobe
  input wire logic rd_in,  // Read strobe
  output logic [31:0] rdata_out,  // Read data, cycle after rd_in
  input wire logic usb_reset_in,  // USB reset pulse
  input wire logic lite_soft_reset_in,  // Lite reset pulse
  input wire logic image_load_in,  // Config image load strobe
  input wire logic image_valid_in,  // Image came from EEPROM or OTP
  input wire logic [71:0] image_in,  // Six 12-bit latency defaults
  input wire logic frame_store_in,  // Rx frame stored pulse
  input wire logic [15:0] frame_len_in,  // Stored frame length in bytes
  input wire logic [15:0] frame_extra_in,  // Command words and checksums
  input wire logic rx_read_in,  // Rx FIFO drained bytes pulse
  input wire logic [15:0] rx_read_bytes_in,  // Bytes drained
  input wire logic rx_flush_in,  // Rx FIFO flush
  input wire logic [15:0] usb_out_fifo_bytes_in,  // Usb-out FIFO bytes
  input wire logic [15:0] usb_in_fifo_bytes_in,  // Usb-in FIFO bytes
  input wire logic [15:0] tx_fifo_bytes_in,  // Tx frame FIFO bytes
  input wire fifo_sizing_pkg::link_speed_type speed_in,  // Link speed
  input wire logic path_empty_in,  // All data path FIFOs empty
  output logic [15:0] rx_fifo_last_out,  // Rx last address, dwords
  output logic [15:0] tx_fifo_last_out,  // Tx last address, dwords
  output logic flow_on_out,  // Pause frame generation request
  output logic [15:0] rx_fifo_bytes_held_out,  // Rx FIFO occupancy
  output fifo_sizing_pkg::ltm_state_type ltm_state_out,  // LTM state
  output logic [11:0] latency_out  // Latency tolerance in use
);
  import fifo_sizing_pkg::*;

  function automatic logic [15:0] fifo_last(input logic [6:0] sel);
    fifo_last = 16'(sel) * 16'(`FIFO_END_MUL) + 16'(`FIFO_END_ADD);
  endfunction : fifo_last

  function automatic logic [11:0] pick_latency(
    input link_speed_type sp,
    input logic [11:0] gig,
    input logic [11:0] fast,
    input logic [11:0] slow
  );
    case (sp)
      SPEED_1000: pick_latency = gig;
      SPEED_100: pick_latency = fast;
      SPEED_10: pick_latency = slow;
      default: pick_latency = 12'h000;
    endcase
  endfunction : pick_latency

  // Write strobe decode, shared by every writable offset
  function automatic logic wr_hit(
    input logic wr,
    input logic [7:0] addr,
    input logic [7:0] off
  );
    wr_hit = wr && (addr == off);
  endfunction : wr_hit

  logic [6:0] rx_end_q;
  logic [5:0] tx_end_q;
  logic [6:0] wm_on_q;
  logic [6:0] wm_off_q;
  // Latency fields in use; image_q keeps the copy soft resets restore
  logic [11:0] idle_gig_q;
  logic [11:0] idle_fast_q;
  logic [11:0] idle_slow_q;
  logic [11:0] act_gig_q;
  logic [11:0] act_fast_q;
  logic [11:0] act_slow_q;
  logic [71:0] image_q;
  logic [15:0] occ_q;
  logic [15:0] occ_d;
  logic flow_q;
  logic flow_d;
  logic [15:0] timer_load_q;
  logic [15:0] countdown_q;
  logic [31:0] step_cnt_q;
  ltm_state_type ltm_q;
  // Read mux output, registered into rdata_out on a read strobe
  logic [31:0] rdata_q;

  wire soft_restore = usb_reset_in | lite_soft_reset_in;
  wire wr_rx_end = wr_hit(wr_in, addr_in, `RX_FIFO_END_SEL_OFF);
  wire wr_tx_end = wr_hit(wr_in, addr_in, `TX_FIFO_END_SEL_OFF);
  wire wr_wm = wr_hit(wr_in, addr_in, `PAUSE_WATERMARKS_OFF);
  wire wr_idle_fast = wr_hit(wr_in, addr_in, `LAT_IDLE_FAST_OFF);
  wire wr_idle_slow = wr_hit(wr_in, addr_in, `LAT_IDLE_SLOW_OFF);
  wire wr_act_fast = wr_hit(wr_in, addr_in, `LAT_ACT_FAST_OFF);
  wire wr_act_slow = wr_hit(wr_in, addr_in, `LAT_ACT_SLOW_OFF);
  wire wr_ltm = wr_hit(wr_in, addr_in, `LTM_CTRL_OFF);

  // Frame adds its length rounded to a dword plus stored extras
  wire [15:0] frame_round = (frame_len_in + 16'h0003) & 16'hfffc;
  wire [15:0] add_bytes = frame_store_in ?
    16'(frame_round + frame_extra_in) : 16'h0000;
  wire [15:0] sub_bytes = rx_read_in ? rx_read_bytes_in : 16'h0000;
  wire [6:0] occ_units = occ_q[15:`WATERMARK_UNIT_SHIFT];
  wire at_or_above_on = occ_units >= wm_on_q;
  wire at_or_below_off = occ_units <= wm_off_q;
  wire [15:0] rx_total = 16'(usb_out_fifo_bytes_in + occ_q);
  wire [15:0] tx_total = 16'(usb_in_fifo_bytes_in + tx_fifo_bytes_in);
  wire step_tick = step_cnt_q == 32'(STEP_CYCLES - 1);

  // Occupancy wraps silently; the FIFO itself refuses to overfill
  always_comb begin
    if (rx_flush_in) begin
      occ_d = 16'h0000;
    end else begin
      occ_d = 16'(occ_q + add_bytes - sub_bytes);
    end
  end

  // On wins when both thresholds are met; when neither is met, state holds
  always_comb begin
    if (at_or_above_on) begin
      flow_d = 1'b1;
    end else if (at_or_below_off) begin
      flow_d = 1'b0;
    end else begin
      flow_d = flow_q;
    end
  end

  always_comb begin
    case (addr_in)
      `RX_FIFO_END_SEL_OFF: rdata_q = {25'h0, rx_end_q};
      `TX_FIFO_END_SEL_OFF: rdata_q = {26'h0, tx_end_q};
      `PAUSE_WATERMARKS_OFF: rdata_q = {17'h0, wm_off_q, 1'b0, wm_on_q};
      `RX_PATH_OCC_OFF: rdata_q = {rx_total, usb_out_fifo_bytes_in};
      `TX_PATH_OCC_OFF: rdata_q = {tx_total, usb_in_fifo_bytes_in};
      `LAT_IDLE_FAST_OFF: rdata_q = {4'h0, idle_gig_q, 4'h0, idle_fast_q};
      `LAT_IDLE_SLOW_OFF: rdata_q = {20'h0, idle_slow_q};
      `LAT_ACT_FAST_OFF: rdata_q = {4'h0, act_gig_q, 4'h0, act_fast_q};
      `LAT_ACT_SLOW_OFF: rdata_q = {20'h0, act_slow_q};
      `FLOW_STATUS_OFF: rdata_q = {15'h0, ltm_q, occ_q[14:0], flow_q};
      `LTM_CTRL_OFF: rdata_q = {16'h0, timer_load_q};
      default: rdata_q = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= 32'h0000_0000;
    end else begin
      // Read data stand one cycle only and return to zero
      if (rd_in) begin
        rdata_out <= rdata_q;
      end else begin
        rdata_out <= 32'h0000_0000;
      end
    end
  end

  // Ends above 12 KB are not refused; software keeps them in range

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_end_q <= `FIFO_END_RST;
      tx_end_q <= 6'(`FIFO_END_RST);
      wm_on_q <= 7'h00;
      wm_off_q <= 7'h00;
    end else begin
      if (wr_rx_end) begin
        rx_end_q <= wdata_in[6:0];
      end
      if (wr_tx_end) begin
        tx_end_q <= wdata_in[5:0];
      end
      if (wr_wm) begin
        wm_on_q <= wdata_in[`WM_ON_LSB +: 7];
        wm_off_q <= wdata_in[`WM_OFF_LSB +: 7];
      end
    end
  end

  // Image is held so that soft resets can reload it without a source
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      image_q <= 72'h0;
    end else if (image_load_in) begin
      image_q <= image_valid_in ? image_in : 72'h0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      idle_gig_q <= `LAT_RST;
      idle_fast_q <= `LAT_RST;
      idle_slow_q <= `LAT_RST;
      act_gig_q <= `LAT_RST;
      act_fast_q <= `LAT_RST;
      act_slow_q <= `LAT_RST;
    end else if (soft_restore || image_load_in) begin
      {act_slow_q, act_fast_q, act_gig_q,
       idle_slow_q, idle_fast_q, idle_gig_q} <=
        soft_restore ? image_q :
        (image_valid_in ? image_in : 72'h0);
    end else begin
      if (wr_idle_fast) begin
        idle_gig_q <= wdata_in[`LAT_GIG_LSB +: 12];
        idle_fast_q <= wdata_in[`LAT_LOW_LSB +: 12];
      end
      if (wr_idle_slow) begin
        idle_slow_q <= wdata_in[11:0];
      end
      if (wr_act_fast) begin
        act_gig_q <= wdata_in[`LAT_GIG_LSB +: 12];
        act_fast_q <= wdata_in[`LAT_LOW_LSB +: 12];
      end
      if (wr_act_slow) begin
        act_slow_q <= wdata_in[11:0];
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      // Flush wins over a store or drain in the same cycle
      occ_q <= 16'h0000;
      flow_q <= 1'b0;
    end else begin
      occ_q <= occ_d;
      flow_q <= flow_d;
    end
  end

  // Countdown reloads while traffic flows; idle once it reaches zero
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      timer_load_q <= 16'h0000;
      countdown_q <= 16'h0000;
      step_cnt_q <= 32'h0000_0000;
      ltm_q <= LTM_ACTIVE;
    end else begin
      if (wr_ltm) begin
        timer_load_q <= wdata_in[15:0];
      end
      // Step counter restarts whenever traffic is seen
      if (!path_empty_in || step_tick) begin
        step_cnt_q <= 32'h0000_0000;
      end else begin
        step_cnt_q <= step_cnt_q + 32'h0000_0001;
      end
      if (!path_empty_in) begin
        countdown_q <= timer_load_q;
        ltm_q <= LTM_ACTIVE;
      end else if (countdown_q == 16'h0000) begin
        ltm_q <= LTM_IDLE;
      end else if (step_tick) begin
        countdown_q <= countdown_q - 16'h0001;
      end
    end
  end

  // Software alone keeps end values steady while the paths run
  // and sets watermarks before enabling pause sending
  assign rx_fifo_last_out = fifo_last(rx_end_q);
  // Tx end is six bits wide, so the top select bit is always zero
  assign tx_fifo_last_out = fifo_last({1'b0, tx_end_q});
  assign flow_on_out = flow_q;
  assign rx_fifo_bytes_held_out = occ_q;
  assign ltm_state_out = ltm_q;
  assign latency_out = (ltm_q == LTM_IDLE) ?
    pick_latency(speed_in, idle_gig_q, idle_fast_q, idle_slow_q) :
    pick_latency(speed_in, act_gig_q, act_fast_q, act_slow_q);
endmodule : fifo_sizing_flow_ltm_regs
`default_nettype wire

/* File: bench/fifo_sizing_asserts.sv */
// Checker bound to the FIFO sizing register bank.
// Assumes watermarks change only through register writes.
`default_nettype none
module fifo_sizing_asserts #(parameter int STEP_CYCLES = 4000) (
  input wire logic clk_in,  // Clock
  input wire logic rst_n_in,  // Reset
  input wire logic [7:0] addr_in,  // Address
  input wire logic [31:0] wdata_in,  // Data
  input wire logic wr_in,  // Write
  input wire logic rd_in,  // Read
  input wire logic [31:0] rdata_out,  // Read data
  input wire logic frame_store_in,  // Store
  input wire logic [15:0] frame_len_in,  // Length
  input wire logic [15:0] frame_extra_in,  // Extra
  input wire logic rx_read_in,  // Drain
  input wire logic rx_flush_in,  // Flush
  input wire logic [15:0] usb_out_fifo_bytes_in,  // Usb-out
  input wire logic path_empty_in,  // Empty
  input wire logic [15:0] rx_fifo_last_out,  // Rx last
  input wire logic [15:0] tx_fifo_last_out,  // Tx last
  input wire logic flow_on_out,  // Flow
  input wire logic [15:0] rx_fifo_bytes_held_out,  // Held
  input wire fifo_sizing_pkg::ltm_state_type ltm_state_out  // State
);
  import fifo_sizing_pkg::*;
  logic [6:0] on_q, off_q;
  wire logic [15:0] held = rx_fifo_bytes_held_out;
  wire logic [6:0] lvl = held[15:9];
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      on_q <= 7'h00;
      off_q <= 7'h00;
    end else if (wr_in && addr_in == 8'hd0) begin
      on_q <= wdata_in[6:0];
      off_q <= wdata_in[14:8];
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_rx_last_map: assert property (wr_in && addr_in == 8'hc8 |=>
    rx_fifo_last_out == {2'h0, $past(wdata_in[6:0]), 7'h7f})
    else $error("rx last address mismatch");
  a_tx_last_map: assert property (wr_in && addr_in == 8'hcc |=>
    tx_fifo_last_out == {3'h0, $past(wdata_in[5:0]), 7'h7f})
    else $error("tx last address mismatch");
  a_flow_turn_on: assert property (lvl >= on_q |=> flow_on_out)
    else $error("flow control not on");
  a_flow_turn_off: assert property (lvl < on_q && lvl <= off_q |=>
    !flow_on_out) else $error("flow control not off");
  a_flow_hold: assert property (lvl < on_q && lvl > off_q |=>
    $stable(flow_on_out)) else $error("flow control changed");
  a_occ_grow: assert property (frame_store_in && !rx_read_in &&
    !rx_flush_in |=> held == 16'($past(held) + $past(frame_extra_in) +
    (($past(frame_len_in) + 16'h0003) & 16'hfffc)))
    else $error("occupancy growth wrong");
  a_rx_path_word: assert property (rd_in && addr_in == 8'hd4 |=>
    rdata_out == {16'($past(usb_out_fifo_bytes_in) + $past(held)),
    $past(usb_out_fifo_bytes_in)}) else $error("rx path word wrong");
  a_busy_active: assert property (!path_empty_in |=>
    ltm_state_out == LTM_ACTIVE) else $error("ltm state not active");
  c_flow_on: cover property ($rose(flow_on_out));
  c_idle: cover property (ltm_state_out == LTM_IDLE);
  c_store: cover property (frame_store_in);
endmodule : fifo_sizing_asserts
bind fifo_sizing_flow_ltm_regs fifo_sizing_asserts #(
  .STEP_CYCLES(STEP_CYCLES)) u_chk (.*);
`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench for the FIFO sizing register bank.
// Assumes the checker is bound in; 40 MHz clock, short LTM step.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import fifo_sizing_pkg::*;
  logic clk_in = 1'b0, rst_n_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
  logic usb_reset_in = 1'b0, lite_soft_reset_in = 1'b0, rd_d = 1'b0;
  logic image_load_in = 1'b0, image_valid_in = 1'b0, rx_flush_in = 1'b0;
  logic frame_store_in = 1'b0, rx_read_in = 1'b0, path_empty_in = 1'b0;
  logic flow_on_out;
  logic [7:0] addr_in = 8'h00;
  logic [11:0] latency_out;
  logic [31:0] wdata_in = 32'h0000_0000, rdata_out, r;
  logic [71:0] image_in = 72'h0, img;
  logic [15:0] frame_len_in = 16'h0000, frame_extra_in = 16'h0000;
  logic [15:0] rx_read_bytes_in = 16'h0000, tx_fifo_bytes_in = 16'h0000;
  logic [15:0] usb_out_fifo_bytes_in = 16'h0000;
  logic [15:0] usb_in_fifo_bytes_in = 16'h0000;
  logic [15:0] rx_fifo_last_out, tx_fifo_last_out, rx_fifo_bytes_held_out;
  link_speed_type speed_in = SPEED_100;
  ltm_state_type ltm_state_out;
  // Expected read data wait here until their answer cycle
  logic [31:0] exp_q[$];
  integer seed = 32'h90ac17c7;
  int n_errors = 0, cmp_count = 0, cyc = 0;
  fifo_sizing_flow_ltm_regs #(.STEP_CYCLES(4)) dut (.*);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk_in);
    rd_in <= 1'b0;
  endtask : rd
  task automatic ctl(input logic u, lt, ld, fl);
    @(posedge clk_in);
    usb_reset_in <= u;
    lite_soft_reset_in <= lt;
    image_load_in <= ld;
    rx_flush_in <= fl;
    @(posedge clk_in);
    {usb_reset_in, lite_soft_reset_in, image_load_in, rx_flush_in} <= 4'h0;
  endtask : ctl
  // A zero length means no frame is stored in this step
  task automatic step(input logic [15:0] len, ext, drop, occ,
      input logic fl);
    @(posedge clk_in);
    frame_store_in <= len != 16'h0000;
    rx_read_in <= drop != 16'h0000;
    frame_len_in <= len;
    frame_extra_in <= ext;
    rx_read_bytes_in <= drop;
    @(posedge clk_in);
    {frame_store_in, rx_read_in} <= 2'b00;
    @(negedge clk_in);
    chk(rx_fifo_bytes_held_out, occ);
    @(negedge clk_in);
    chk(flow_on_out, fl);
  endtask : step
  always @(posedge clk_in) begin
    rd_d <= rd_in;
    cyc <= cyc + 1;
    if (rd_d) chk(rdata_out, exp_q.pop_front());
    if (cyc == 3000) begin
      n_errors++;
      final_report();
    end
  end
  initial forever #12.5 clk_in = ~clk_in;
  initial begin
    repeat (10) @(posedge clk_in);
    rst_n_in <= 1'b1;
    chk(rx_fifo_last_out, 32'h0000_0bff);
    chk(tx_fifo_last_out, 32'h0000_0bff);
    rd(8'hc8, 32'h0000_0017);
    rd(8'hd0, 32'h0000_0000);
    rd(8'h44, 32'h0000_0000);
    $display("reset values done");
    r = $random(seed);
    wr(8'hc8, r);
    wr(8'hcc, ~r);
    wr(8'hd4, r);
    ctl(1'b0, 1'b0, 1'b0, 1'b1);
    rd(8'hc8, {25'h0, r[6:0]});
    rd(8'hcc, {26'h0, ~r[5:0]});
    rd(8'hd4, 32'h0000_0000);
    chk(rx_fifo_last_out, {18'h0, r[6:0], 7'h7f});
    chk(tx_fifo_last_out, {19'h0, ~r[5:0], 7'h7f});
    $display("fifo end done");
    wr(8'hd0, 32'h0000_0204);
    step(16'h07fd, 16'h0000, 16'h0000, 16'h0800, 1'b1);
    step(16'h0000, 16'h0000, 16'h0200, 16'h0600, 1'b1);
    step(16'h0000, 16'h0000, 16'h0200, 16'h0400, 1'b0);
    step(16'h01fd, 16'h0004, 16'h0000, 16'h0604, 1'b0);
    rd(8'hf8, 32'h0000_0c08);
    $display("flow control done");
    r = $random(seed);
    @(posedge clk_in);
    usb_out_fifo_bytes_in <= r[15:0];
    usb_in_fifo_bytes_in <= r[31:16];
    tx_fifo_bytes_in <= ~r[15:0];
    rd(8'hd4, {r[15:0] + 16'h0604, r[15:0]});
    rd(8'hd8, {r[31:16] + ~r[15:0], r[31:16]});
    $display("data path done");
    img = {r[7:0], $random(seed), $random(seed)};
    image_in <= img;
    image_valid_in <= 1'b1;
    ctl(1'b0, 1'b0, 1'b1, 1'b0);
    rd(8'he0, {4'h0, img[11:0], 4'h0, img[23:12]});
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_in);
      speed_in <= link_speed_type'(i);
      path_empty_in <= 1'b0;
      repeat (2) @(negedge clk_in);
      chk(latency_out, img[36 + 12 * (2 - i) +: 12]);
      @(posedge clk_in);
      path_empty_in <= 1'b1;
      repeat (3) @(negedge clk_in);
      chk(ltm_state_out, LTM_IDLE);
      chk(latency_out, img[12 * (2 - i) +: 12]);
    end
    wr(8'hfc, 32'h0000_0002);
    @(posedge clk_in);
    path_empty_in <= 1'b0;
    @(posedge clk_in);
    path_empty_in <= 1'b1;
    repeat (9) @(negedge clk_in);
    chk(ltm_state_out, LTM_ACTIVE);
    @(negedge clk_in);
    chk(ltm_state_out, LTM_IDLE);
    wr(8'he8, 32'hffff_ffff);
    rd(8'he8, 32'h0fff_0fff);
    ctl(1'b1, 1'b0, 1'b0, 1'b0);
    rd(8'he8, {4'h0, img[47:36], 4'h0, img[59:48]});
    image_valid_in <= 1'b0;
    ctl(1'b0, 1'b0, 1'b1, 1'b0);
    wr(8'he4, r);
    ctl(1'b0, 1'b1, 1'b0, 1'b0);
    rd(8'he4, 32'h0000_0000);
    rd(8'hec, 32'h0000_0000);
    $display("latency done");
    repeat (3) @(posedge clk_in);
    final_report();
  end
endmodule : testbench
`default_nettype wire
